// ===== hw/sbs_brake_seq.sv
// Holding-brake and motor power stop sequencer with its register port.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "sbs_map.svh"

module sbs_brake_seq #(
  parameter int unsigned TICK_CYCLES = `SBS_TICK_CYCLES, // cycles per 10 ms
  parameter logic [13:0] MAX_SPEED = 14'h1770, // motor maximum speed, 1 min^-1
  parameter logic [13:0] ROT_LEVEL = 14'h0014, // speed seen as rotating
  parameter bit CTRL_LOSS_COAST = 1'b0 // variant: coast on control power loss
) (
  input wire logic mclk, // system clock, 250 MHz
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic cfg_restart, // drive restart, loads restart-only fields
  input wire logic servo_on, // servo-on command
  input wire logic alarm_class_one, // class-one alarm present
  input wire logic alarm_class_two, // class-two alarm present
  input wire logic [13:0] motor_speed, // speed magnitude, 1 min^-1
  input wire sbs_pkg::sbs_ctrl_mode_t ctrl_mode, // control mode
  input wire logic main_power_lost, // main circuit power lost
  input wire logic ctrl_power_lost, // control power lost
  output logic brake_release_out, // high releases the holding brake
  output logic motor_power_en, // motor power stage enabled
  output logic dynamic_brake_stop, // dynamic brake engaged
  output logic zero_speed_ref, // internal speed reference forced to 0
  output logic rotation_detect_out // motor speed at or above rotation level
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [`SBS_DELAY_W-1:0] pwr_delay_reg;
  logic [`SBS_LEVEL_W-1:0] spd_level_reg;
  logic [`SBS_WAIT_W-1:0] run_wait_reg;
  sbs_pkg::sbs_stop_cfg_t stop_pend_reg;
  sbs_pkg::sbs_stop_cfg_t stop_cfg_reg;
  sbs_pkg::sbs_state_t state_reg;
  sbs_pkg::sbs_state_t state_next;
  logic [6:0] tick_cnt_reg;
  logic via_zero_reg;
  logic tick;
  logic cnt_restart;
  logic moving;
  logic fault;
  logic stop_req;
  logic zero_pick;
  logic [`SBS_LEVEL_W-1:0] level_eff;
  sbs_pkg::sbs_drive_t drv_next;

  function automatic logic [`SBS_LEVEL_W-1:0] clamp_level(
    input logic [`SBS_LEVEL_W-1:0] lvl,
    input logic [`SBS_LEVEL_W-1:0] lim
  );
    return (lvl > lim) ? lim : lvl;
  endfunction

  // Standstill stop: hold power for the programmed delay, or cut at once if it is zero.
  function automatic sbs_pkg::sbs_state_t standstill_stop(
    input logic [`SBS_DELAY_W-1:0] dly
  );
    return (dly == 6'h0) ? sbs_pkg::SBS_ST_STOPPED : sbs_pkg::SBS_ST_HOLD_DELAY;
  endfunction

  // Power-cut stop: a rotating motor waits for its brake, a halted one stops at once.
  function automatic sbs_pkg::sbs_state_t cut_stop(
    input logic rotating
  );
    return rotating ? sbs_pkg::SBS_ST_RUN_WAIT : sbs_pkg::SBS_ST_STOPPED;
  endfunction

  // Dynamic brake while the motor still turns: every method but coast-coast brakes.
  function automatic logic db_rotating(
    input sbs_pkg::sbs_stop_method_t mth
  );
    return mth != sbs_pkg::SBS_STOP_COAST_COAST;
  endfunction

  // Delay and run-wait values above the documented range are pinned so counts stay bounded.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_delay_reg <= `SBS_RST_PWR_DELAY;
      spd_level_reg <= `SBS_RST_SPD_LEVEL;
      run_wait_reg <= `SBS_RST_RUN_WAIT;
    end else if (reg_wr) begin
      if (reg_addr == `SBS_OFF_PWR_DELAY) begin
        pwr_delay_reg <= (reg_wdata[5:0] > `SBS_MAX_PWR_DELAY) ?
          `SBS_MAX_PWR_DELAY : reg_wdata[5:0];
      end
      if (reg_addr == `SBS_OFF_SPD_LEVEL) begin
        spd_level_reg <= reg_wdata[13:0];
      end
      if (reg_addr == `SBS_OFF_RUN_WAIT) begin
        if (reg_wdata[6:0] < `SBS_MIN_RUN_WAIT) begin
          run_wait_reg <= `SBS_MIN_RUN_WAIT;
        end else if (reg_wdata[6:0] > `SBS_MAX_RUN_WAIT) begin
          run_wait_reg <= `SBS_MAX_RUN_WAIT;
        end else begin
          run_wait_reg <= reg_wdata[6:0];
        end
      end
    end
  end

  // Stop fields are written freely but only take hold at a restart.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_pend_reg.stop_method <= sbs_pkg::sbs_stop_method_t'(`SBS_RST_STOP_METHOD);
      stop_pend_reg.class_two_db <= `SBS_RST_CLASS_TWO;
    end else if (reg_wr && reg_addr == `SBS_OFF_STOP_CFG) begin
      stop_pend_reg.stop_method <= (reg_wdata[1:0] == 2'h3) ?
        sbs_pkg::SBS_STOP_COAST_COAST : sbs_pkg::sbs_stop_method_t'(reg_wdata[1:0]);
      stop_pend_reg.class_two_db <= reg_wdata[`SBS_CLASS_TWO_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_cfg_reg.stop_method <= sbs_pkg::sbs_stop_method_t'(`SBS_RST_STOP_METHOD);
      stop_cfg_reg.class_two_db <= `SBS_RST_CLASS_TWO;
    end else if (cfg_restart) begin
      stop_cfg_reg <= stop_pend_reg;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SBS_OFF_PWR_DELAY: reg_rdata <= {26'h0, pwr_delay_reg};
        `SBS_OFF_SPD_LEVEL: reg_rdata <= {18'h0, spd_level_reg};
        `SBS_OFF_RUN_WAIT: reg_rdata <= {25'h0, run_wait_reg};
        `SBS_OFF_STOP_CFG: reg_rdata <= {27'h0, stop_pend_reg.class_two_db, 2'h0,
          stop_pend_reg.stop_method};
        // Status is read only; a write to it matches no field and is dropped.
        `SBS_OFF_STATUS: reg_rdata <= {23'h0, stop_cfg_reg, via_zero_reg,
          rotation_detect_out, zero_speed_ref, dynamic_brake_stop, motor_power_en,
          brake_release_out};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Millisecond timing
  // ****************************************
  // 10 ms tick source
  sbs_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(cnt_restart),
    .tick(tick)
  );

  // The divider is realigned at each trigger so a wait of N ticks lasts a full N x 10 ms.
  assign cnt_restart = (state_next != state_reg);

  // Saturation keeps a long wait from wrapping back into a short one.
  // tick count from trigger
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 7'h0;
    end else if (cnt_restart) begin
      tick_cnt_reg <= 7'h0;
    end else if (tick && tick_cnt_reg != 7'h7f) begin
      tick_cnt_reg <= tick_cnt_reg + 7'h1;
    end
  end

  // ****************************************
  // Stop decision
  // ****************************************
  assign moving = (motor_speed >= ROT_LEVEL);
  assign fault = alarm_class_one || main_power_lost || ctrl_power_lost;
  assign stop_req = !servo_on || fault || alarm_class_two;
  assign level_eff = clamp_level(spd_level_reg, MAX_SPEED);
  assign zero_pick = alarm_class_two && !fault && !stop_cfg_reg.class_two_db &&
    ctrl_mode != sbs_pkg::SBS_MODE_TORQUE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sbs_pkg::SBS_ST_OFF, sbs_pkg::SBS_ST_STOPPED: begin
        if (!stop_req) begin
          state_next = sbs_pkg::SBS_ST_RUN;
        end
      end
      sbs_pkg::SBS_ST_RUN: begin
        if (zero_pick) begin
          state_next = sbs_pkg::SBS_ST_ZERO_STOP;
        end else if (fault || alarm_class_two) begin
          state_next = cut_stop(moving);
        end else if (!servo_on) begin
          state_next = moving ? sbs_pkg::SBS_ST_RUN_WAIT : standstill_stop(pwr_delay_reg);
        end
      end
      sbs_pkg::SBS_ST_ZERO_STOP: begin
        if (fault) begin
          state_next = cut_stop(moving);
        // zero stop ends in standstill timing
        end else if (!moving) begin
          state_next = standstill_stop(pwr_delay_reg);
        end
      end
      sbs_pkg::SBS_ST_HOLD_DELAY: begin
        // The delay is compared live, so a value written mid-count at or below the ticks counted ends it at once.
        // live delay compare
        if (fault || (alarm_class_two && !via_zero_reg) ||
            {1'b0, tick_cnt_reg} >= {2'h0, pwr_delay_reg}) begin
          state_next = sbs_pkg::SBS_ST_STOPPED;
        end
      end
      sbs_pkg::SBS_ST_RUN_WAIT: begin
        if (motor_speed < level_eff || tick_cnt_reg >= run_wait_reg) begin
          state_next = sbs_pkg::SBS_ST_STOPPED;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= sbs_pkg::SBS_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remembers a stop that began as a zero-speed stop, whose brake is already applied.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      via_zero_reg <= 1'b0;
    end else if (state_next == sbs_pkg::SBS_ST_RUN) begin
      via_zero_reg <= 1'b0;
    end else if (state_next == sbs_pkg::SBS_ST_ZERO_STOP) begin
      via_zero_reg <= 1'b1;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  // Dynamic brake is chosen from the state the machine is entering, so every
  // drive output changes on the same edge as the state and none lags the others.
  always_comb begin
    drv_next = '0;
    unique case (state_next)
      sbs_pkg::SBS_ST_RUN: begin
        drv_next.brake_release = 1'b1;
        drv_next.power_en = 1'b1;
      end
      sbs_pkg::SBS_ST_ZERO_STOP: begin
        drv_next.power_en = 1'b1;
        drv_next.zero_ref = 1'b1;
      end
      sbs_pkg::SBS_ST_HOLD_DELAY: begin
        drv_next.power_en = 1'b1;
      end
      sbs_pkg::SBS_ST_RUN_WAIT: begin
        // A zero-speed stop has applied the brake already; an alarm must not release it.
        drv_next.brake_release = !via_zero_reg;
        drv_next.dyn_brake = db_rotating(stop_cfg_reg.stop_method);
      end
      sbs_pkg::SBS_ST_STOPPED: begin
        if (moving) begin
          drv_next.dyn_brake = db_rotating(stop_cfg_reg.stop_method);
        end else begin
          drv_next.dyn_brake = (stop_cfg_reg.stop_method == sbs_pkg::SBS_STOP_DB_HOLD);
        end
      end
      default: begin
        drv_next = '0;
      end
    endcase
    // Power loss overrides the method only once the power stage is off.
    // control power loss variant
    if (ctrl_power_lost && !drv_next.power_en) begin
      drv_next.dyn_brake = !CTRL_LOSS_COAST;
    end
    if (main_power_lost && !drv_next.power_en) begin
      drv_next.dyn_brake = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      brake_release_out <= 1'b0;
      motor_power_en <= 1'b0;
      dynamic_brake_stop <= 1'b0;
      zero_speed_ref <= 1'b0;
      rotation_detect_out <= 1'b0;
    end else begin
      brake_release_out <= drv_next.brake_release;
      motor_power_en <= drv_next.power_en;
      dynamic_brake_stop <= drv_next.dyn_brake;
      zero_speed_ref <= drv_next.zero_ref;
      rotation_detect_out <= moving;
    end
  end

endmodule // sbs_brake_seq

// ===== hw/sbs_tick_gen.sv
// Divider that turns the system clock into a one-cycle 10 ms enable.
`timescale 1ns/1ns
module sbs_tick_gen #(
  parameter int unsigned TICK_CYCLES = 2500000
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic restart, // realigns the divider to zero
  output logic tick // one-cycle pulse every TICK_CYCLES
);

  logic [31:0] div_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end else if (restart || div_reg == TICK_CYCLES - 1) begin
      div_reg <= 32'h0;
      tick <= !restart;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule // sbs_tick_gen

// ===== shared/sbs_map.svh
// Register offsets, field positions, reset values and timing counts of the stop sequencer.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SBS_OFF_PWR_DELAY 8'h00
`define SBS_OFF_SPD_LEVEL 8'h04
`define SBS_OFF_RUN_WAIT 8'h08
`define SBS_OFF_STOP_CFG 8'h0c
`define SBS_OFF_STATUS 8'h10

// ****************************************
// Field positions and widths
// ****************************************
`define SBS_STOP_METHOD_LSB 0
`define SBS_CLASS_TWO_BIT 4
`define SBS_DELAY_W 6
`define SBS_LEVEL_W 14
`define SBS_WAIT_W 7

// ****************************************
// Reset values and write limits
// ****************************************
`define SBS_RST_PWR_DELAY 6'h00
`define SBS_RST_SPD_LEVEL 14'h0064
`define SBS_RST_RUN_WAIT 7'h32
`define SBS_RST_STOP_METHOD 2'h0
`define SBS_RST_CLASS_TWO 1'h0
`define SBS_MIN_RUN_WAIT 7'h0a
`define SBS_MAX_PWR_DELAY 6'h32
`define SBS_MAX_RUN_WAIT 7'h64

// ****************************************
// Timing
// ****************************************
`define SBS_CLK_PERIOD_NS 4
`define SBS_TICK_NS 10000000
`define SBS_TICK_CYCLES (`SBS_TICK_NS / `SBS_CLK_PERIOD_NS)

`endif

// ===== shared/sbs_pkg.sv
// Types shared by the stop sequencer files.
package sbs_pkg;

  typedef enum logic [1:0] {
    SBS_STOP_DB_HOLD,
    SBS_STOP_DB_COAST,
    SBS_STOP_COAST_COAST,
    SBS_STOP_RSVD
  } sbs_stop_method_t;

  typedef enum logic [1:0] {
    SBS_MODE_POSITION,
    SBS_MODE_SPEED,
    SBS_MODE_TORQUE,
    SBS_MODE_RSVD
  } sbs_ctrl_mode_t;

  typedef enum {
    SBS_ST_OFF,
    SBS_ST_RUN,
    SBS_ST_ZERO_STOP,
    SBS_ST_HOLD_DELAY,
    SBS_ST_RUN_WAIT,
    SBS_ST_STOPPED
  } sbs_state_t;

  typedef struct packed {
    sbs_stop_method_t stop_method;
    logic class_two_db;
  } sbs_stop_cfg_t;

  typedef struct packed {
    logic brake_release;
    logic power_en;
    logic dyn_brake;
    logic zero_ref;
  } sbs_drive_t;

endpackage

// ===== testbench/sbs_brake_seq_monitor.sv
// Checker of the stop sequencer output timing.
`timescale 1ns/1ns
module sbs_brake_seq_monitor #(
  parameter int unsigned TICK_CYCLES = 4 // cycles per 10 ms
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic servo_on, // servo-on
  input wire logic alarm_class_one, // class-one alarm
  input wire logic alarm_class_two, // class-two alarm
  input wire sbs_pkg::sbs_ctrl_mode_t ctrl_mode, // control mode
  input wire logic main_power_lost, // main power lost
  input wire logic ctrl_power_lost, // control power lost
  input wire logic brake_release_out, // brake released
  input wire logic motor_power_en, // motor powered
  input wire logic dynamic_brake_stop, // dynamic brake on
  input wire logic zero_speed_ref, // zero reference
  input wire logic rotation_detect_out // rotating
);
  // ****************************************
  // Properties
  // ****************************************
  // The longest running wait is 100 ticks; the slack covers divider alignment.
  localparam int WAIT_MAX = 100 * TICK_CYCLES + 8;
  int free_cnt;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      free_cnt <= 0;
    end else if (brake_release_out && !motor_power_en) begin
      free_cnt <= free_cnt + 1;
    end else begin
      free_cnt <= 0;
    end
  end
  a_servo_off_brake: assert property ($fell(servo_on) && !rotation_detect_out |=>
    !brake_release_out) else $error("brake held after standstill servo-off");
  a_alarm_cut: assert property (alarm_class_one || main_power_lost |=> !motor_power_en)
    else $error("power stayed on after alarm or power loss");
  a_main_loss_db: assert property (main_power_lost && !ctrl_power_lost |=>
    dynamic_brake_stop) else $error("no dynamic brake on main power loss");
  a_zero_ref_power: assert property (zero_speed_ref |-> motor_power_en)
    else $error("zero reference without power");
  a_zero_ref_cause: assert property ($rose(zero_speed_ref) |-> $past(alarm_class_two) &&
    $past(ctrl_mode) != sbs_pkg::SBS_MODE_TORQUE) else $error("zero stop without cause");
  a_db_no_power: assert property (dynamic_brake_stop |-> !motor_power_en)
    else $error("dynamic brake with power on");
  a_brake_needs_run: assert property ($rose(brake_release_out) |-> $past(servo_on) &&
    !$past(alarm_class_one) && !$past(alarm_class_two)) else $error("brake released in stop");
  a_wait_bound: assert property (free_cnt <= WAIT_MAX)
    else $error("brake released too long without power");
endmodule // sbs_brake_seq_monitor
bind sbs_brake_seq sbs_brake_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.mclk, .sys_rst,
  .servo_on, .alarm_class_one, .alarm_class_two, .ctrl_mode, .main_power_lost,
  .ctrl_power_lost, .brake_release_out, .motor_power_en, .dynamic_brake_stop,
  .zero_speed_ref, .rotation_detect_out);

// ===== testbench/sbs_motor_model.sv
// Motor model: follows the host speed while powered without zero_ref, else slows only under zero_ref or slow_en.
`timescale 1ns/1ns
module sbs_motor_model (
  input wire logic mclk, // clock
  input wire logic power_en, // power stage on
  input wire logic zero_ref, // speed reference forced to 0
  input wire logic slow_en, // friction or braking present
  input wire logic [13:0] cmd_speed, // speed asked by the host
  output logic [13:0] speed // measured speed magnitude
);
  initial speed = 14'h0000;
  // A zero reference brakes actively; without power only friction slows it.
  always @(posedge mclk) begin
    if (power_en && !zero_ref) begin
      speed <= cmd_speed;
    end else if (slow_en || zero_ref) begin
      speed <= (speed > 14'h0040) ? speed - 14'h0040 : 14'h0000;
    end
  end
endmodule // sbs_motor_model

// ===== testbench/test_sbs_brake_seq.sv
// Self-checking bench for the stop sequencer with a motor model.
`timescale 1ns/1ns
module test_sbs_brake_seq;
  // ****************************************
  // Signals
  // ****************************************
  localparam int TICK = 4;
  localparam bit CLC = 1'b0;
  logic mclk, sys_rst, reg_wr, reg_rd, cfg_restart, servo_on, slow_en;
  logic alarm_class_one, alarm_class_two, main_power_lost, ctrl_power_lost;
  logic brake_release_out, motor_power_en, dynamic_brake_stop, zero_speed_ref;
  logic rotation_detect_out;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [13:0] motor_speed, cmd_speed;
  sbs_pkg::sbs_ctrl_mode_t ctrl_mode;
  int bad_count = 0;
  int n_tests = 0;
  sbs_brake_seq #(.TICK_CYCLES(TICK), .CTRL_LOSS_COAST(CLC)) u_dut (.mclk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_restart, .servo_on,
    .alarm_class_one, .alarm_class_two, .motor_speed, .ctrl_mode, .main_power_lost,
    .ctrl_power_lost, .brake_release_out, .motor_power_en, .dynamic_brake_stop,
    .zero_speed_ref, .rotation_detect_out);
  sbs_motor_model u_motor (.mclk, .power_en(motor_power_en), .zero_ref(zero_speed_ref),
    .slow_en, .cmd_speed, .speed(motor_speed));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Counts cycles until power (pw) or brake reaches v; running out ends the run.
  task automatic wt(input bit pw, input logic v, input int lim, output int n);
    n = 0;
    while ((pw ? motor_power_en : brake_release_out) !== v && n < lim) begin
      tk(1);
      n++;
    end
    if ((pw ? motor_power_en : brake_release_out) !== v) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic rst_cfg(input logic [31:0] d);
    wr(8'h0c, d);
    @(posedge mclk);
    cfg_restart <= 1'b1;
    @(posedge mclk);
    cfg_restart <= 1'b0;
  endtask
  task automatic go(input logic [13:0] s, input logic sl);
    int n;
    // A stop still in progress keeps the brake up; let it end before a fresh start.
    wt(1'b0, 1'b0, 600, n);
    @(posedge mclk);
    {alarm_class_one, alarm_class_two, main_power_lost, ctrl_power_lost} <= 4'h0;
    servo_on <= 1'b1;
    cmd_speed <= s;
    slow_en <= sl;
    wt(1'b0, 1'b1, 600, n);
    tk(3);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h64);
    rd(8'h08, 32'h32);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h3f);
    rd(8'h00, 32'h32);
    wr(8'h08, 32'h05);
    rd(8'h08, 32'h0a);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h0);
  endtask
  task automatic t_still();
    int n;
    wr(8'h00, 32'h02);
    go(14'h0000, 1'b1);
    @(posedge mclk);
    servo_on <= 1'b0;
    tk(1);
    chk(32'({brake_release_out, motor_power_en}), 32'h1);
    wt(1'b1, 1'b0, 40, n);
    chk(32'(n >= 2 * TICK - 2 && n <= 2 * TICK + 3), 32'h1);
    chk(32'(dynamic_brake_stop), 32'h1);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_run();
    int n;
    go(14'h03e8, 1'b0);
    @(posedge mclk);
    alarm_class_one <= 1'b1;
    slow_en <= 1'b1;
    tk(1);
    chk(32'({brake_release_out, motor_power_en, dynamic_brake_stop}), 32'h5);
    rd(8'h10, 32'h15);
    wt(1'b0, 1'b0, 30, n);
    chk(32'(motor_speed < 14'h0064), 32'h1);
  endtask
  task automatic t_wait(input logic [13:0] s);
    int n;
    go(s, 1'b0);
    @(posedge mclk);
    alarm_class_one <= 1'b1;
    tk(1);
    wt(1'b0, 1'b0, 60, n);
    chk(32'(n >= 10 * TICK - 2 && n <= 10 * TICK + 3), 32'h1);
  endtask
  task automatic t_two(input sbs_pkg::sbs_ctrl_mode_t m, input logic [31:0] c);
    int n;
    logic zs;
    zs = (m != sbs_pkg::SBS_MODE_TORQUE) && !c[4];
    rst_cfg(c);
    ctrl_mode <= m;
    go(14'h03e8, 1'b1);
    @(posedge mclk);
    alarm_class_two <= 1'b1;
    tk(1);
    chk(32'({zero_speed_ref, motor_power_en}), 32'({zs, zs}));
    wt(1'b1, 1'b0, 40, n);
    chk(32'({zero_speed_ref, dynamic_brake_stop}), 32'h1);
  endtask
  task automatic t_methods();
    int n;
    for (int m = 0; m < 3; m++) begin
      rst_cfg(32'(m));
      go(14'h03e8, 1'b1);
      @(posedge mclk);
      servo_on <= 1'b0;
      tk(1);
      chk(32'(dynamic_brake_stop), 32'(m != 2));
      wt(1'b0, 1'b0, 40, n);
      tk(4);
      chk(32'(dynamic_brake_stop), 32'(m == 0));
    end
  endtask
  task automatic t_loss();
    rst_cfg(32'h2);
    for (int i = 0; i < 2; i++) begin
      go(14'h03e8, 1'b1);
      @(posedge mclk);
      main_power_lost <= (i == 0);
      ctrl_power_lost <= (i == 1);
      tk(1);
      chk(32'(dynamic_brake_stop), 32'(i == 0 || !CLC));
    end
    rst_cfg(32'h0);
  endtask
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, cfg_restart, servo_on, slow_en} = 5'h00;
    {alarm_class_one, alarm_class_two, main_power_lost, ctrl_power_lost} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cmd_speed = 14'h0000;
    ctrl_mode = sbs_pkg::SBS_MODE_POSITION;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_still();
    t_run();
    t_wait(14'h03e8);
    wr(8'h04, 32'h2710);
    t_wait(14'h1964);
    wr(8'h04, 32'h64);
    t_two(sbs_pkg::SBS_MODE_POSITION, 32'h0);
    t_two(sbs_pkg::SBS_MODE_TORQUE, 32'h0);
    t_two(sbs_pkg::SBS_MODE_POSITION, 32'h10);
    t_methods();
    t_loss();
    finish_test();
  end
endmodule // test_sbs_brake_seq
